// ===== src/btc_pkg.sv
`default_nettype none

package btc_pkg;

    // ****************************************************************
    // register indices on the byte register port
    // ****************************************************************
    localparam int IDX_W = 4;
    localparam logic [3:0] IDX_COMPARE_A_HIGH = 4'h0;
    localparam logic [3:0] IDX_COMPARE_A_LOW = 4'h1;
    localparam logic [3:0] IDX_COMPARE_B_HIGH = 4'h2;
    localparam logic [3:0] IDX_COMPARE_B_LOW = 4'h3;
    localparam logic [3:0] IDX_TRACE_FIFO_HIGH = 4'h4;
    localparam logic [3:0] IDX_TRACE_FIFO_LOW = 4'h5;
    localparam logic [3:0] IDX_TRACE_CONTROL = 4'h6;

    // ****************************************************************
    // trace_control field positions
    // ****************************************************************
    localparam int CTL_MODULE_ENABLE = 7;
    localparam int CTL_CAPTURE_ACTIVE = 6;
    localparam int CTL_BREAK_KIND = 5;
    localparam int CTL_BREAK_ENABLE = 4;
    localparam int CTL_A_DIRECTION = 3;
    localparam int CTL_A_DIRECTION_ENABLE = 2;
    localparam int CTL_B_DIRECTION = 1;
    localparam int CTL_B_DIRECTION_ENABLE = 0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] FIFO_WORD_RESET = 16'h0000;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************************************
    // trigger_mode codes
    // ****************************************************************
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVENT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_B = 4'h5;
    localparam logic [3:0] MODE_A_AND_NOT_B = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;

    // ****************************************************************
    // trace buffer
    // ****************************************************************
    localparam int FIFO_DEPTH = 8;
    localparam int COUNT_W = 4;

    typedef enum logic [1:0] {
        BTC_IDLE,
        BTC_WAIT_TRIGGER,
        BTC_FILL
    } btc_state_e;

endpackage : btc_pkg

`default_nettype wire

// ===== src/btc_trace_comparator.sv
// Behaviour
// - seven register bytes, reachable through the ordinary memory map.
// - comparator bytes reset to 0x00, always readable, writes ignored while armed.
// - fifo high byte read-only; reads 0x00 in event-only trigger modes.
// - reading fifo high byte never advances the fifo; read it before low.
// - reading fifo low byte advances the fifo; writes have no effect.
// - event-only modes store 8-bit data in the low half of each word.
// - while armed, low-byte reads do not advance the fifo.
// - unarmed low-byte read pushes latest opcode fetch address into last slot.
// - profiling: ninth read returns the address captured by the first read.
// - trace_control readable and writable at all times.
// - bit 7 enables module; cannot be set while device is secure.
// - writing 1 to bit 6 together with bit 7 arms capture and flag; cleared on run completion.
// - writing 0 to arm or enable stops the run at once.
// - bit 5 selects force (0) or tag (1) break kind.
// - bit 4 enables break requests; triggers still store data regardless.
// - begin trace breaks when fifo fills; end trace breaks on trigger.
// - trigger qualify select does not change break request timing.
// - bit 3: comparator A matches writes when 0, reads when 1.
// - bit 2 low makes comparator A ignore direction.
// - bit 1: comparator B matches writes when 0, reads when 1.
// - bit 0 low makes comparator B ignore direction.
// - run completes on fifo full (begin) or trigger event (end).
// - outside event-only modes, start select 0 fills circularly until trigger; 1 starts at trigger.
// - modes 0011/0100 are event-only, storing on B events (0100 after A).
`timescale 1ns/1ps
`default_nettype none

module btc_trace_comparator #(
    parameter int DEPTH = btc_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [btc_pkg::IDX_W-1:0] reg_index,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_data,
    input wire logic cpu_valid,
    input wire logic cpu_read,
    input wire logic cpu_opfetch,
    input wire logic secure,
    input wire logic [3:0] trigger_mode,
    input wire logic trigger_qualify_select,
    input wire logic trace_start_select,
    output logic break_req,
    output logic break_tag,
    output logic capture_active_flag,
    output logic [btc_pkg::COUNT_W-1:0] fifo_count
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic dir_ok(input logic en, input logic dir, input logic rd);
        dir_ok = !en || (dir == rd);
    endfunction : dir_ok

    function automatic logic is_event_mode(input logic [3:0] m);
        is_event_mode = (m == btc_pkg::MODE_EVENT_B) || (m == btc_pkg::MODE_A_THEN_EVENT_B);
    endfunction : is_event_mode

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] cmp_a_high;
    logic [7:0] cmp_a_low;
    logic [7:0] cmp_b_high;
    logic [7:0] cmp_b_low;
    logic [7:0] control;
    logic [15:0] fifo_mem [DEPTH];
    logic [15:0] last_fetch;
    logic [btc_pkg::COUNT_W-1:0] count;
    logic a_seen;
    logic brk;
    logic [7:0] rdata;
    btc_pkg::btc_state_e state;

    logic [7:0] next_cmp_a_high;
    logic [7:0] next_cmp_a_low;
    logic [7:0] next_cmp_b_high;
    logic [7:0] next_cmp_b_low;
    logic [7:0] next_control;
    logic [15:0] next_fifo_mem [DEPTH];
    logic [15:0] next_last_fetch;
    logic [btc_pkg::COUNT_W-1:0] next_count;
    logic next_a_seen;
    logic next_brk;
    logic [7:0] next_rdata;
    btc_pkg::btc_state_e next_state;

    // ****************************************************************
    // decode and match
    // ****************************************************************
    logic enabled;
    logic armed;
    logic running;
    logic event_mode;
    logic begin_mode;
    logic qual;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic a_hit;
    logic b_hit;
    logic trig;
    logic store;
    logic [15:0] store_word;
    logic full_now;
    logic done;
    logic ctl_wr;
    logic cmp_wr;
    logic arm_start;
    logic advance;

    always_comb begin
        enabled = control[btc_pkg::CTL_MODULE_ENABLE];
        armed = control[btc_pkg::CTL_CAPTURE_ACTIVE];
        running = enabled && armed;
        event_mode = is_event_mode(trigger_mode);
        // event-only modes always run as begin traces
        begin_mode = trace_start_select || event_mode;
        // qualified triggers only count opcode fetches
        qual = cpu_valid && (!trigger_qualify_select || cpu_opfetch);
        cmp_a = {cmp_a_high, cmp_a_low};
        cmp_b = {cmp_b_high, cmp_b_low};
        a_hit = qual && (cpu_addr == cmp_a)
            && dir_ok(control[btc_pkg::CTL_A_DIRECTION_ENABLE],
                      control[btc_pkg::CTL_A_DIRECTION], cpu_read);
        b_hit = qual && (cpu_addr == cmp_b)
            && dir_ok(control[btc_pkg::CTL_B_DIRECTION_ENABLE],
                      control[btc_pkg::CTL_B_DIRECTION], cpu_read);
        case (trigger_mode)
            btc_pkg::MODE_A_ONLY: trig = a_hit;
            btc_pkg::MODE_A_OR_B: trig = a_hit || b_hit;
            btc_pkg::MODE_A_THEN_B: trig = b_hit && a_seen;
            btc_pkg::MODE_A_AND_B: trig = a_hit && b_hit;
            btc_pkg::MODE_A_AND_NOT_B: trig = a_hit && !b_hit;
            btc_pkg::MODE_INSIDE: trig = qual && (cpu_addr >= cmp_a) && (cpu_addr <= cmp_b);
            btc_pkg::MODE_OUTSIDE: trig = qual && ((cpu_addr < cmp_a) || (cpu_addr > cmp_b));
            default: trig = 1'b0;
        endcase
        if (event_mode) begin
            // data byte of a B access, the second mode needs a prior A match
            trig = b_hit && ((trigger_mode == btc_pkg::MODE_EVENT_B) || a_seen);
            store = running && trig;
            store_word = {btc_pkg::READ_ZERO, cpu_data};
        end else begin
            // normal modes record the flow of fetched opcode addresses
            store = running && cpu_valid && cpu_opfetch
                && (!begin_mode || state == btc_pkg::BTC_FILL || trig);
            store_word = cpu_addr;
        end
        full_now = store && (count == btc_pkg::COUNT_W'(DEPTH - 1));
        // completion timing is independent of the qualify select
        done = running && (begin_mode ? full_now : trig);
        ctl_wr = reg_write && (reg_index == btc_pkg::IDX_TRACE_CONTROL);
        cmp_wr = reg_write && !armed;
        arm_start = ctl_wr && reg_wdata[btc_pkg::CTL_CAPTURE_ACTIVE]
            && reg_wdata[btc_pkg::CTL_MODULE_ENABLE] && !secure && !running;
        // reads advance only when not armed
        advance = reg_read && (reg_index == btc_pkg::IDX_TRACE_FIFO_LOW) && !armed;
    end

    // ****************************************************************
    // next values
    // ****************************************************************
    always_comb begin
        next_cmp_a_high = cmp_a_high;
        next_cmp_a_low = cmp_a_low;
        next_cmp_b_high = cmp_b_high;
        next_cmp_b_low = cmp_b_low;
        next_control = control;
        next_fifo_mem = fifo_mem;
        next_last_fetch = last_fetch;
        next_count = count;
        next_a_seen = a_seen;
        next_brk = 1'b0;
        next_rdata = rdata;
        next_state = state;

        if (cmp_wr) begin
            case (reg_index)
                btc_pkg::IDX_COMPARE_A_HIGH: next_cmp_a_high = reg_wdata;
                btc_pkg::IDX_COMPARE_A_LOW: next_cmp_a_low = reg_wdata;
                btc_pkg::IDX_COMPARE_B_HIGH: next_cmp_b_high = reg_wdata;
                btc_pkg::IDX_COMPARE_B_LOW: next_cmp_b_low = reg_wdata;
                default: next_cmp_a_high = cmp_a_high;
            endcase
        end

        if (cpu_valid && cpu_opfetch) begin
            next_last_fetch = cpu_addr;
        end

        if (running && a_hit) begin
            next_a_seen = 1'b1;
        end

        // completion clears the arm bit unless a write rearms it
        if (done) begin
            next_control[btc_pkg::CTL_CAPTURE_ACTIVE] = 1'b0;
            next_brk = control[btc_pkg::CTL_BREAK_ENABLE];
            next_state = btc_pkg::BTC_IDLE;
        end else if (running && begin_mode && !event_mode && trig) begin
            next_state = btc_pkg::BTC_FILL;
        end

        if (store) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_fifo_mem[i] = fifo_mem[i + 1];
            end
            next_fifo_mem[DEPTH - 1] = store_word;
            if (count != btc_pkg::COUNT_W'(DEPTH)) begin
                next_count = count + 1'b1;
            end
        end else if (advance) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_fifo_mem[i] = fifo_mem[i + 1];
            end
            next_fifo_mem[DEPTH - 1] = last_fetch;
        end

        if (ctl_wr) begin
            next_control = reg_wdata;
            // enable only sticks when not secure
            next_control[btc_pkg::CTL_MODULE_ENABLE] =
                reg_wdata[btc_pkg::CTL_MODULE_ENABLE] && !secure;
            next_control[btc_pkg::CTL_CAPTURE_ACTIVE] =
                reg_wdata[btc_pkg::CTL_CAPTURE_ACTIVE] && !secure
                && reg_wdata[btc_pkg::CTL_MODULE_ENABLE];
            if (!next_control[btc_pkg::CTL_CAPTURE_ACTIVE]) begin
                next_state = btc_pkg::BTC_IDLE;
            end
        end

        if (arm_start) begin
            next_count = '0;
            next_a_seen = 1'b0;
            next_brk = 1'b0;
            next_state = (begin_mode && !event_mode) ? btc_pkg::BTC_WAIT_TRIGGER
                                                     : btc_pkg::BTC_FILL;
        end

        if (reg_read) begin
            case (reg_index)
                btc_pkg::IDX_COMPARE_A_HIGH: next_rdata = cmp_a_high;
                btc_pkg::IDX_COMPARE_A_LOW: next_rdata = cmp_a_low;
                btc_pkg::IDX_COMPARE_B_HIGH: next_rdata = cmp_b_high;
                btc_pkg::IDX_COMPARE_B_LOW: next_rdata = cmp_b_low;
                btc_pkg::IDX_TRACE_FIFO_HIGH:
                    next_rdata = event_mode ? btc_pkg::READ_ZERO : fifo_mem[0][15:8];
                btc_pkg::IDX_TRACE_FIFO_LOW: next_rdata = fifo_mem[0][7:0];
                btc_pkg::IDX_TRACE_CONTROL: next_rdata = control;
                default: next_rdata = btc_pkg::READ_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmp_a_high <= btc_pkg::COMPARE_RESET;
            cmp_a_low <= btc_pkg::COMPARE_RESET;
            cmp_b_high <= btc_pkg::COMPARE_RESET;
            cmp_b_low <= btc_pkg::COMPARE_RESET;
            control <= btc_pkg::CONTROL_RESET;
            for (int i = 0; i < DEPTH; i++) begin
                fifo_mem[i] <= btc_pkg::FIFO_WORD_RESET;
            end
            last_fetch <= btc_pkg::FIFO_WORD_RESET;
            count <= '0;
            a_seen <= 1'b0;
            brk <= 1'b0;
            rdata <= btc_pkg::READ_ZERO;
            state <= btc_pkg::BTC_IDLE;
        end else begin
            cmp_a_high <= next_cmp_a_high;
            cmp_a_low <= next_cmp_a_low;
            cmp_b_high <= next_cmp_b_high;
            cmp_b_low <= next_cmp_b_low;
            control <= next_control;
            fifo_mem <= next_fifo_mem;
            last_fetch <= next_last_fetch;
            count <= next_count;
            a_seen <= next_a_seen;
            brk <= next_brk;
            rdata <= next_rdata;
            state <= next_state;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = rdata;
    assign break_req = brk;
    assign break_tag = control[btc_pkg::CTL_BREAK_KIND];
    assign capture_active_flag = running;
    assign fifo_count = count;

endmodule : btc_trace_comparator

`default_nettype wire

// ===== verif/btc_trace_comparator_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// port checks of the trace comparator
// ****
module btc_trace_comparator_assertions #(
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [btc_pkg::IDX_W-1:0] reg_index,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic secure,
    input wire logic [3:0] trigger_mode,
    input wire logic break_req,
    input wire logic capture_active_flag,
    input wire logic [btc_pkg::COUNT_W-1:0] fifo_count
);
    logic ctl_wr;
    logic fifo_hi_rd;
    logic event_mode;
    assign ctl_wr = reg_write && reg_index == btc_pkg::IDX_TRACE_CONTROL;
    assign fifo_hi_rd = reg_read && reg_index == btc_pkg::IDX_TRACE_FIFO_HIGH;
    assign event_mode = trigger_mode == 4'h3 || trigger_mode == 4'h4;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    property p_unmapped;
        reg_read && reg_index > 4'h6 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rdata_hold;
        !reg_read |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_event_high;
        fifo_hi_rd && event_mode |=> reg_rdata == 8'h00;
    endproperty
    a_event_high: assert property (p_event_high) else $error("event high not zero");
    property p_secure;
        secure && !capture_active_flag |=> !capture_active_flag;
    endproperty
    a_secure: assert property (p_secure) else $error("armed while secure");
    property p_arm;
        ctl_wr && reg_wdata[7:6] == 2'b11 && !secure |=> capture_active_flag && fifo_count == 4'h0;
    endproperty
    a_arm: assert property (p_arm) else $error("arm write not taken");
    property p_disarm;
        ctl_wr && reg_wdata[7:6] != 2'b11 |=> !capture_active_flag;
    endproperty
    a_disarm: assert property (p_disarm) else $error("run not stopped");
    property p_break_armed;
        break_req |-> $past(capture_active_flag);
    endproperty
    a_break_armed: assert property (p_break_armed) else $error("break while idle");
    property p_break_ends;
        break_req && !$past(reg_write) |-> !capture_active_flag;
    endproperty
    a_break_ends: assert property (p_break_ends) else $error("arm kept after run");
    property p_break_pulse;
        break_req |=> !break_req;
    endproperty
    a_break_pulse: assert property (p_break_pulse) else $error("break too long");
    property p_count_max;
        fifo_count <= DEPTH;
    endproperty
    a_count_max: assert property (p_count_max) else $error("count above depth");
    property p_count_grows;
        capture_active_flag && !ctl_wr |=> fifo_count >= $past(fifo_count);
    endproperty
    a_count_grows: assert property (p_count_grows) else $error("count fell");
endmodule : btc_trace_comparator_assertions

bind btc_trace_comparator btc_trace_comparator_assertions #(.DEPTH(DEPTH)) u_chk (
    .mclk(mclk), .rstn(rstn), .reg_index(reg_index), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .secure(secure),
    .trigger_mode(trigger_mode), .break_req(break_req),
    .capture_active_flag(capture_active_flag), .fifo_count(fifo_count)
);

`default_nettype wire

// ===== verif/btc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****
// cpu side: runs bus cycles, counts break requests
// ****
module btc_cpu_model (
    input wire logic mclk,
    input wire logic break_req,
    output logic [15:0] cpu_addr,
    output logic [7:0] cpu_data,
    output logic cpu_valid,
    output logic cpu_read,
    output logic cpu_opfetch
);
    int breaks = 0;
    initial begin
        cpu_addr = 16'hffff;
        cpu_data = 8'hff;
        cpu_valid = 1'b0;
        cpu_read = 1'b1;
        cpu_opfetch = 1'b0;
    end
    always @(posedge mclk) begin
        if (break_req === 1'b1) begin
            breaks <= breaks + 1;
        end
    end
    // idle cycles show the inverse address, data and direction of the last cycle, and no fetch
    task automatic cycle(input logic [15:0] a, input logic r, input logic f,
                         input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_data <= d;
        cpu_read <= r;
        cpu_opfetch <= f;
        cpu_valid <= 1'b1;
        @(posedge mclk);
        cpu_valid <= 1'b0;
        cpu_opfetch <= 1'b0;
        cpu_addr <= ~a;
        cpu_data <= ~d;
        cpu_read <= ~r;
    endtask : cycle
endmodule : btc_cpu_model

`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk;
    logic rstn;
    logic [3:0] reg_index;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [15:0] cpu_addr;
    logic [7:0] cpu_data;
    logic cpu_valid;
    logic cpu_read;
    logic cpu_opfetch;
    logic secure;
    logic [3:0] trigger_mode;
    logic trigger_qualify_select;
    logic trace_start_select;
    logic break_req;
    logic break_tag;
    logic capture_active_flag;
    logic [3:0] fifo_count;
    logic [7:0] rv;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int brk_base = 0;

    btc_trace_comparator #(.DEPTH(8)) u_dut (
        .mclk(mclk), .rstn(rstn), .reg_index(reg_index), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .cpu_addr(cpu_addr), .cpu_data(cpu_data), .cpu_valid(cpu_valid),
        .cpu_read(cpu_read), .cpu_opfetch(cpu_opfetch), .secure(secure),
        .trigger_mode(trigger_mode), .trigger_qualify_select(trigger_qualify_select),
        .trace_start_select(trace_start_select), .break_req(break_req),
        .break_tag(break_tag), .capture_active_flag(capture_active_flag),
        .fifo_count(fifo_count)
    );
    btc_cpu_model u_cpu (
        .mclk(mclk), .break_req(break_req), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
        .cpu_valid(cpu_valid), .cpu_read(cpu_read), .cpu_opfetch(cpu_opfetch)
    );

    // ****
    // clock, timeout and report
    // ****
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        @(posedge mclk);
        reg_index <= i;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] i);
        @(posedge mclk);
        reg_index <= i;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    task automatic rdchk(input logic [3:0] i, input logic [7:0] e, input string what);
        rd(i);
        chk(what, e, rv);
    endtask : rdchk
    // one armed run: arm, one bus cycle, then look at break and arm state
    task automatic run(input logic [3:0] m, input logic [7:0] c, input logic [15:0] a,
                       input logic r, input logic q, input logic eb, input logic ef);
        int b0;
        b0 = u_cpu.breaks;
        @(posedge mclk);
        trigger_mode <= m;
        trigger_qualify_select <= q;
        wr(4'h6, c);
        u_cpu.cycle(a, r, q, 8'h00);
        repeat (2) @(posedge mclk);
        #1 chk("break count", eb, 16'(u_cpu.breaks - b0));
        chk("armed flag", ef, capture_active_flag);
        chk("break kind", c[5], break_tag);
        wr(4'h6, 8'h00);
        #1 chk("stopped", 1'b0, capture_active_flag);
    endtask : run

    initial begin
        rstn = 1'b0;
        reg_index = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
        secure = 1'b0;
        trigger_mode = 4'h0;
        trigger_qualify_select = 1'b0;
        trace_start_select = 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i < 4 || i > 5) begin
                rdchk(4'(i), 8'h00, "reset read");
            end
        end
        wr(4'h0, 8'h12);
        wr(4'h1, 8'h34);
        wr(4'h2, 8'h56);
        wr(4'h3, 8'h78);
        rdchk(4'h0, 8'h12, "compare_a_high");
        rdchk(4'h3, 8'h78, "compare_b_low");
        @(posedge mclk);
        secure <= 1'b1;
        wr(4'h6, 8'hc0);
        rdchk(4'h6, 8'h00, "secure control");
        @(posedge mclk);
        secure <= 1'b0;
        $display("test registers done");
        for (int k = 0; k < 9; k++) begin
            u_cpu.cycle(16'h2a10 + 16'(k), 1'b1, 1'b1, 8'h00);
            if (k == 8) begin
                rdchk(4'h4, 8'h2a, "profile high");
                rdchk(4'h4, 8'h2a, "profile high again");
            end
            rd(4'h5);
        end
        chk("profile low", 8'h10, rv);
        $display("test profiling done");
        @(posedge mclk);
        trigger_mode <= btc_pkg::MODE_EVENT_B;
        wr(4'h6, 8'hc0);
        wr(4'h3, 8'h11);
        for (int k = 0; k < 8; k++) begin
            u_cpu.cycle(16'h5678, 1'b0, 1'b0, 8'ha0 + 8'(k));
            if (k == 3) begin
                rd(4'h5);
                rd(4'h5);
            end
        end
        @(posedge mclk);
        #1 chk("event run ended", 1'b0, capture_active_flag);
        chk("event count", 4'h8, fifo_count);
        rdchk(4'h3, 8'h78, "compare_b_low armed write");
        wr(4'h5, 8'hff);
        wr(4'h4, 8'hff);
        for (int k = 0; k < 8; k++) begin
            rdchk(4'h4, 8'h00, "event high");
            rdchk(4'h5, 8'ha0 + 8'(k), "event low");
        end
        chk("count kept", 4'h8, fifo_count);
        $display("test event trace done");
        run(4'h0, 8'hd0, 16'h1234, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h0, 8'hdc, 16'h1234, 1'b0, 1'b0, 1'b0, 1'b1);
        run(4'h0, 8'hdc, 16'h1234, 1'b1, 1'b0, 1'b1, 1'b0);
        run(4'h0, 8'hd8, 16'h1234, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h1, 8'hd3, 16'h5678, 1'b0, 1'b0, 1'b0, 1'b1);
        run(4'h1, 8'hd3, 16'h5678, 1'b1, 1'b0, 1'b1, 1'b0);
        run(4'h1, 8'hd2, 16'h5678, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h0, 8'hc0, 16'h1234, 1'b0, 1'b0, 1'b0, 1'b0);
        run(4'h0, 8'hf0, 16'h1234, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h0, 8'hd0, 16'h1234, 1'b0, 1'b1, 1'b1, 1'b0);
        run(4'h0, 8'hd0, 16'h1111, 1'b0, 1'b0, 1'b0, 1'b1);
        run(4'h2, 8'hd0, 16'h5678, 1'b0, 1'b0, 1'b0, 1'b1);
        run(4'h6, 8'hd0, 16'h1234, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h7, 8'hd0, 16'h3000, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h8, 8'hd0, 16'h1111, 1'b0, 1'b0, 1'b1, 1'b0);
        run(4'h9, 8'hd0, 16'h1234, 1'b0, 1'b0, 1'b0, 1'b1);
        $display("test break table done");
        // begin trace: a fetch before the trigger is not stored
        @(posedge mclk);
        trigger_mode <= btc_pkg::MODE_A_ONLY;
        trigger_qualify_select <= 1'b0;
        trace_start_select <= 1'b1;
        brk_base = u_cpu.breaks;
        wr(4'h6, 8'hd0);
        u_cpu.cycle(16'h2000, 1'b1, 1'b1, 8'h00);
        #1 chk("begin wait count", 4'h0, fifo_count);
        for (int k = 0; k < 8; k++) begin
            u_cpu.cycle(16'h1234 + 16'(k), 1'b1, 1'b1, 8'h00);
        end
        repeat (2) @(posedge mclk);
        #1 chk("begin break", 16'(brk_base + 1), 16'(u_cpu.breaks));
        chk("begin run ended", 1'b0, capture_active_flag);
        chk("begin count", 4'h8, fifo_count);
        rdchk(4'h4, 8'h12, "begin high");
        rdchk(4'h5, 8'h34, "begin low");
        $display("test begin trace done");
        results();
    end
endmodule : tb_top

`default_nettype wire
